//--- dv/sic_slave_model.sv
/*
 * Behavioural slave on the open-drain clock and data pair.
 * Assumes the bench resolves the wired lines with pull-ups and holds rst
 * until the first frame so that the slot count starts at a frame boundary.
 */
`timescale 1ns/1ps
module sic_slave_model (
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic send,
    input wire logic ack_en,
    input wire logic [7:0] tx_byte,
    output logic sda_oe,
    output logic [7:0] got_byte,
    output logic got_ack
);
    int rises;
    int slot;

    // Eight data slots MSB first, then the acknowledge slot.
    always @(posedge scl or posedge rst) begin
        if (rst) begin
            rises = 0;
        end else begin
            if (rises < 8) begin
                got_byte = {got_byte[6:0], sda};
            end else begin
                got_ack = sda;
            end
            rises = (rises == 8) ? 0 : rises + 1;
        end
    end

    // Drive changes only while the clock is low, so no false start or stop.
    always @(negedge scl or posedge rst) begin
        if (rst) begin
            slot <= 0;
        end else begin
            slot <= rises;
        end
    end

    // Released means pulled high; the model never drives a one.
    assign sda_oe = rst ? 1'b0 : (slot < 8) ? send & ~tx_byte[7 - slot]
        : ack_en & ~send;
endmodule : sic_slave_model

//--- dv/testbench.sv
/*
 * Self-checking bench of the simplified I2C master channel.
 * Assumes the register map and one-wait-cycle bus of the package.
 */
`timescale 1ns/1ps
module testbench
    import sic_pkg::*;
;
    logic core_clk, reset, s_rst, s_send, s_ack, got_ack;
    logic [7:0] s_byte, got_byte;
    sic_avm_req_t req;
    logic [31:0] rdata, q;
    logic waitreq, irq, scl_oe, sda_oe, slv_oe, scl, sda, scl_q;
    int err_count, checks_done, div, k, half, sel, mask_m, run, n;
    int hi_q[$];
    int lo_q[$];
    logic [31:0] rst_val[10] = '{32'h200, 2, 0, 3, 0, 0, 0, 32'h18, 0, 0};

    assign scl = ~scl_oe;
    assign sda = ~(sda_oe | slv_oe);

    sic_main DUT (.core_clk(core_clk), .reset(reset), .avm_req(req),
        .avm_readdata(rdata), .avm_waitrequest(waitreq),
        .transfer_end_irq(irq), .serial_clock_pin_i(scl),
        .serial_clock_pin_o(), .serial_clock_pin_oe(scl_oe),
        .serial_data_pin_i(sda), .serial_data_pin_o(),
        .serial_data_pin_oe(sda_oe));

    sic_slave_model slave (.rst(s_rst), .scl(scl), .sda(sda),
        .send(s_send), .ack_en(s_ack), .tx_byte(s_byte), .sda_oe(slv_oe),
        .got_byte(got_byte), .got_ack(got_ack));

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    // Phase lengths of the serial clock, in core clocks.
    always @(posedge core_clk) begin
        if (scl !== scl_q) begin
            if (scl) lo_q.push_back(run);
            else hi_q.push_back(run);
            run = 1;
        end else begin
            run++;
        end
        scl_q = scl;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        req.read <= ~w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        do @(posedge core_clk); while (waitreq !== 1'b0);
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // One frame: start, poll status, then compare phases and events.
    task automatic frame(input logic [7:0] b, input logic [2:0] ev);
        bus(1, SIC_OFS_DATA, (div << SIC_DIV_LSB) | b);
        bus(0, SIC_OFS_STAT, 0);
        // The idle high before a first frame is queued by now, so drop it.
        hi_q.delete();
        lo_q.delete();
        chk(q[SIC_ST_TSF], 1);
        n = 0;
        do begin
            bus(0, SIC_OFS_STAT, 0);
            n++;
        end while (q[SIC_ST_TSF] !== 1'b0 && n < 4000);
        chk(q[SIC_ST_TSF], 0);
        chk(hi_q.size(), 9);
        foreach (hi_q[i]) chk(hi_q[i], half);
        for (int i = 1; i < lo_q.size(); i++) chk(lo_q[i], half);
        bus(0, SIC_OFS_EVT, 0);
        chk(q, ev);
        chk(irq, |(ev & mask_m));
        bus(1, SIC_OFS_EVT, 7);
        chk(irq, 0);
    endtask : frame

    initial begin
        reset = 1;
        req = '0;
        s_rst = 1;
        s_send = 0;
        s_ack = 0;
        s_byte = 0;
        scl_q = 1;
        run = 0;
        void'($urandom(17143));
        repeat (10) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk);
        for (int a = 0; a < 10; a++) begin
            if (a != 5 && a != 6) begin
                bus(0, a[3:0], 0);
                chk(q, rst_val[a]);
            end
        end
        bus(0, 4'ha, 0);
        chk(q, 0);
        chk({scl, sda}, 2'h3);
        // Half periods of at least 128 clocks keep the line below 400 kHz.
        k = $urandom_range(6, 5);
        sel = $urandom_range(1, 0);
        div = $urandom_range(4, 3);
        half = (div + 1) << k;
        bus(1, SIC_OFS_STOP, 1);
        bus(1, SIC_OFS_PRS, sel ? k << 4 : k);
        bus(1, SIC_OFS_MODE, (sel << SIC_CKS_BIT) | 2);
        mask_m = 7;
        bus(1, SIC_OFS_MASK, mask_m);
        bus(1, SIC_OFS_START, 1);
        bus(1, SIC_OFS_SOE, 1);
        s_rst <= 0;
        s_ack <= 1;
        s_byte = $urandom_range(255, 0);
        frame(s_byte, 3'h1);
        chk(got_byte, s_byte);
        s_ack <= 0;
        frame(8'h5a, 3'h5);
        chk(got_byte, 8'h5a);
        bus(1, SIC_OFS_MODE, (sel << SIC_CKS_BIT) | 1);
        s_send <= 1;
        for (int i = 0; i < 3; i++) begin
            s_byte = $urandom_range(255, 0);
            if (i == 2) begin
                bus(1, SIC_OFS_SOE, 0);
                mask_m = 6;
                bus(1, SIC_OFS_MASK, mask_m);
            end
            frame(8'hff, i == 1 ? 3'h3 : 3'h1);
            chk(got_ack, i == 2);
            // The first byte stays unread so that the second one overruns.
            if (i != 0) begin
                bus(0, SIC_OFS_DATA, 0);
                chk(q[7:0], s_byte);
            end
        end
        s_send <= 0;
        bus(1, SIC_OFS_STOP, 1);
        bus(1, SIC_OFS_LVL, 0);
        bus(1, SIC_OFS_LVL, 2);
        bus(1, SIC_OFS_LVL, 3);
        chk({scl, sda}, 2'h3);
        // Let the sensed line levels pass the synchroniser first.
        repeat (2) @(posedge core_clk);
        bus(0, SIC_OFS_STAT, 0);
        chk(q, 32'h18);
        finish_test();
    end

    // Frames take under six thousand cycles each here.
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        finish_test();
    end
endmodule : testbench

//--- hw/sic_main.sv
/*
 * Simplified I2C master channel: frame engine, baud generator and
 * Avalon-MM register slave with interrupt logic.
 * Assumes open-drain pads resolved outside and external pull-ups.
 */
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Rules for this block and the software that drives it
// [RQ1] In reception the only error raised is overrun of an unread byte.
// [RQ2] Software uses transfer-end interrupts only, never buffer-empty; the bench also unmasks the overrun and ack error events (masks 7 and 6).
// [RQ3] Frames are eight data bits MSB first, no parity, one ack slot.
// [RQ4] Output is non-inverted; clock and data rest high when idle; the code leaves the clock low after a frame.
// [RQ5] Software keeps the clock within 400 kHz or 100 kHz.
// [RQ6] Clock rate is operation clock over divider plus one, over two.
// [RQ7] Software never writes zero to the seven-bit divider field.
// [RQ8] The serial clock has equal high and low phases.
// [RQ9] Operation clock is system clock over 2^k, k from a selected field.
// [RQ10] Software stops all channels before changing the system clock.
// [RQ11] Software enables reception then writes dummy ones to start it.
// [RQ12] No acknowledge after the last byte; software then stops.
// [RQ13] Software clears output enable before the last byte arrives.
// [RQ14] Software stops the channel, then makes the stop condition.
// [RQ15] Software holds output enable and leaves pins alone mid-transfer.
// [RQ16] A missing slave acknowledge sets the acknowledge error flag.
// [RQ17] Software sets the pins to open-drain before communicating.
// [RQ18] Transfer-end event fires once per frame after the ninth clock.
// [RQ19] Transfer status is high while shifting, low when done.
module sic_main
    import sic_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire sic_avm_req_t avm_req,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    output logic transfer_end_irq,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe
);
    sic_state_t state_ff, nxt_state;
    logic [6:0] div_ff, nxt_div;
    logic [7:0] mode_ff, nxt_mode;
    logic [7:0] prs_ff, nxt_prs;
    logic soe_ff, nxt_soe;
    logic en_ff, nxt_en;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] rxd_ff, nxt_rxd;
    logic bff_ff, nxt_bff;
    logic tsf_ff, nxt_tsf;
    logic [3:0] bit_ff, nxt_bit;
    logic [6:0] hcnt_ff, nxt_hcnt;
    logic scl_ff, nxt_scl;
    logic sda_ff, nxt_sda;
    logic [2:0] evt_ff, nxt_evt;
    logic [2:0] mask_ff, nxt_mask;
    logic irq_ff, nxt_irq;
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic scl_oe_ff;
    logic sda_oe_ff;

    logic mck_tick;
    logic phase_end;
    logic [1:0] line;
    logic wr_cmt;
    logic rd_cmt;
    logic [2:0] ev_set;
    logic rx_mode;
    logic [3:0] k_sel;

    // Prescaler field chosen by the mode register select bit.
    assign k_sel = mode_ff[SIC_CKS_BIT] ? prs_ff[7:4] : prs_ff[3:0]; // [RQ9]

    sic_tick u_tick (
        .core_clk(core_clk),
        .reset(reset),
        .k(k_sel),
        .tick(mck_tick)
    );

    sic_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d({serial_data_pin_i, serial_clock_pin_i}),
        .q(line)
    );

    // Writes and read side effects land on the edge that ends the wait.
    assign wr_cmt = avm_req.write && !wait_ff;
    assign rd_cmt = avm_req.read && !wait_ff;
    assign rx_mode = mode_ff[SIC_RXE_BIT];
    // Each half period lasts divider plus one operation clocks.
    assign phase_end = mck_tick && (hcnt_ff == div_ff); // [RQ6] [RQ8]

    always_comb begin
        nxt_state = state_ff;
        nxt_div = div_ff;
        nxt_mode = mode_ff;
        nxt_prs = prs_ff;
        nxt_soe = soe_ff;
        nxt_en = en_ff;
        nxt_shift = shift_ff;
        nxt_rxd = rxd_ff;
        nxt_bff = bff_ff;
        nxt_bit = bit_ff;
        nxt_hcnt = hcnt_ff;
        nxt_scl = scl_ff;
        nxt_sda = sda_ff;
        ev_set = 3'h0;
        if (state_ff == SIC_IDLE) begin
            nxt_hcnt = 7'h00;
        end else if (mck_tick) begin
            nxt_hcnt = phase_end ? 7'h00 : hcnt_ff + 7'h01;
        end
        if (rd_cmt && avm_req.address == SIC_OFS_DATA) begin
            nxt_bff = 1'b0;
        end
        case (state_ff)
            SIC_IDLE: begin
                if (en_ff && wr_cmt && avm_req.address == SIC_OFS_DATA) begin
                    nxt_state = SIC_LOW;
                    nxt_shift = avm_req.writedata[7:0];
                    nxt_bit = 4'h0;
                    nxt_scl = 1'b0;
                    if (soe_ff) begin
                        nxt_sda = avm_req.writedata[7]; // [RQ3] [RQ4]
                    end
                end
            end
            SIC_LOW: begin
                if (phase_end) begin
                    nxt_state = SIC_HIGH;
                    nxt_scl = 1'b1;
                end
            end
            SIC_HIGH: begin
                if (phase_end) begin
                    nxt_scl = 1'b0;
                    if (bit_ff == SIC_ACK_SLOT) begin
                        nxt_state = SIC_IDLE;
                        ev_set[SIC_EV_END] = 1'b1; // [RQ18]
                        if (soe_ff) begin
                            nxt_sda = 1'b1;
                        end
                        if (rx_mode) begin
                            nxt_rxd = shift_ff;
                            ev_set[SIC_EV_OVF] = nxt_bff; // [RQ1]
                            nxt_bff = 1'b1;
                        end else begin
                            ev_set[SIC_EV_ACK] = line[1]; // [RQ16]
                        end
                    end else begin
                        nxt_state = SIC_LOW;
                        nxt_shift = {shift_ff[6:0], line[1]}; // [RQ3]
                        nxt_bit = bit_ff + 4'h1;
                        if (soe_ff && bit_ff == 4'h7) begin
                            // Dropping enable leaves the line high: NACK.
                            nxt_sda = !rx_mode; // [RQ12]
                        end else if (soe_ff) begin
                            nxt_sda = shift_ff[6];
                        end
                    end
                end
            end
            default: nxt_state = SIC_IDLE;
        endcase
        if (wr_cmt && state_ff == SIC_IDLE) begin
            if (avm_req.address == SIC_OFS_DATA) begin
                nxt_div = avm_req.writedata[SIC_DIV_MSB:SIC_DIV_LSB];
            end else if (avm_req.address == SIC_OFS_MODE) begin
                nxt_mode = avm_req.writedata[7:0];
            end else if (avm_req.address == SIC_OFS_PRS) begin
                nxt_prs = avm_req.writedata[7:0];
            end else if (avm_req.address == SIC_OFS_LVL) begin
                nxt_sda = avm_req.writedata[SIC_LVL_SDA];
                nxt_scl = avm_req.writedata[SIC_LVL_SCL];
            end else if (avm_req.address == SIC_OFS_SOE) begin
                nxt_soe = avm_req.writedata[0];
            end else if (avm_req.address == SIC_OFS_START) begin
                nxt_en = nxt_en | avm_req.writedata[0];
            end
        end
        // Of the mode register, only the transmit and receive enable bits may change mid-frame to turn the bus round.
        if (wr_cmt && state_ff != SIC_IDLE
                && avm_req.address == SIC_OFS_MODE) begin
            nxt_mode[SIC_TXE_BIT] = avm_req.writedata[SIC_TXE_BIT];
            nxt_mode[SIC_RXE_BIT] = avm_req.writedata[SIC_RXE_BIT];
        end
        // A stop aborts any frame so software can build the stop condition.
        if (wr_cmt && avm_req.address == SIC_OFS_STOP
                && avm_req.writedata[0]) begin
            nxt_en = 1'b0;
            nxt_state = SIC_IDLE;
        end
    end

    // Hardware set wins over a same-cycle write-one clear.
    always_comb begin
        nxt_evt = evt_ff;
        nxt_mask = mask_ff;
        if (wr_cmt && avm_req.address == SIC_OFS_EVT) begin
            nxt_evt = evt_ff & ~avm_req.writedata[2:0];
        end
        if (wr_cmt && avm_req.address == SIC_OFS_MASK) begin
            nxt_mask = avm_req.writedata[2:0];
        end
        nxt_evt = nxt_evt | ev_set;
        nxt_irq = |(nxt_evt & nxt_mask);
        nxt_tsf = nxt_state != SIC_IDLE; // [RQ19]
    end

    // Read data is caught on entry, on the same edge that drops waitrequest.
    always_comb begin
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        if (wait_ff && (avm_req.read || avm_req.write)) begin
            nxt_wait = 1'b0;
        end
        if (wait_ff && avm_req.read) begin
            nxt_rdata = 32'h0000_0000;
            if (avm_req.address == SIC_OFS_DATA) begin
                nxt_rdata[SIC_DIV_MSB:SIC_DIV_LSB] = div_ff;
                nxt_rdata[7:0] = rxd_ff;
            end else if (avm_req.address == SIC_OFS_MODE) begin
                nxt_rdata[7:0] = mode_ff;
            end else if (avm_req.address == SIC_OFS_PRS) begin
                nxt_rdata[7:0] = prs_ff;
            end else if (avm_req.address == SIC_OFS_LVL) begin
                nxt_rdata[SIC_LVL_SDA] = sda_ff;
                nxt_rdata[SIC_LVL_SCL] = scl_ff;
            end else if (avm_req.address == SIC_OFS_SOE) begin
                nxt_rdata[0] = soe_ff;
            end else if (avm_req.address == SIC_OFS_STAT) begin
                nxt_rdata[SIC_ST_EN] = en_ff;
                nxt_rdata[SIC_ST_TSF] = tsf_ff;
                nxt_rdata[SIC_ST_BFF] = bff_ff;
                nxt_rdata[SIC_ST_SCL] = line[0];
                nxt_rdata[SIC_ST_SDA] = line[1];
            end else if (avm_req.address == SIC_OFS_EVT) begin
                nxt_rdata[2:0] = evt_ff;
            end else if (avm_req.address == SIC_OFS_MASK) begin
                nxt_rdata[2:0] = mask_ff;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff <= SIC_IDLE;
            div_ff <= SIC_DIV_RST;
            mode_ff <= SIC_MODE_RST;
            prs_ff <= SIC_PRS_RST;
            soe_ff <= 1'b0;
            en_ff <= 1'b0;
            shift_ff <= 8'h00;
            rxd_ff <= 8'h00;
            bff_ff <= 1'b0;
            tsf_ff <= 1'b0;
            bit_ff <= 4'h0;
            hcnt_ff <= 7'h00;
            scl_ff <= SIC_LVL_RST[SIC_LVL_SCL];
            sda_ff <= SIC_LVL_RST[SIC_LVL_SDA];
            evt_ff <= SIC_EV_RST;
            mask_ff <= SIC_EV_RST;
            irq_ff <= 1'b0;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            mode_ff <= nxt_mode;
            prs_ff <= nxt_prs;
            soe_ff <= nxt_soe;
            en_ff <= nxt_en;
            shift_ff <= nxt_shift;
            rxd_ff <= nxt_rxd;
            bff_ff <= nxt_bff;
            tsf_ff <= nxt_tsf;
            bit_ff <= nxt_bit;
            hcnt_ff <= nxt_hcnt;
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
            evt_ff <= nxt_evt;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            scl_oe_ff <= !nxt_scl; // [RQ4]
            sda_oe_ff <= !nxt_sda; // [RQ4]
        end
    end

    // Open drain: the pad only ever pulls low.
    assign serial_clock_pin_o = 1'b0;
    assign serial_data_pin_o = 1'b0;
    assign serial_clock_pin_oe = scl_oe_ff;
    assign serial_data_pin_oe = sda_oe_ff;
    assign avm_readdata = rdata_ff;
    assign avm_waitrequest = wait_ff;
    assign transfer_end_irq = irq_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_frame_start;
        state_ff == SIC_IDLE ##1 state_ff == SIC_LOW;
    endsequence

    chk_tsf_busy: assert property (s_frame_start |-> tsf_ff) // [RQ19]
        else $error("status low during frame");
    chk_tsf_done: assert property ((state_ff == SIC_HIGH && phase_end // [RQ19]
        && bit_ff == SIC_ACK_SLOT) |=> !tsf_ff && evt_ff[SIC_EV_END])
        else $error("frame end not flagged");
    chk_half_period: assert property ((state_ff == SIC_LOW // [RQ8]
        && phase_end) |=> scl_ff && hcnt_ff == 7'h00)
        else $error("clock phase mismatch");
    chk_phase_len: assert property ((mck_tick && !phase_end // [RQ6]
        && state_ff != SIC_IDLE) |=> hcnt_ff == $past(hcnt_ff) + 7'h01)
        else $error("half period length wrong");
    chk_overrun_set: assert property ((ev_set[SIC_EV_END] && rx_mode // [RQ1]
        && bff_ff && !rd_cmt) |=> evt_ff[SIC_EV_OVF])
        else $error("overrun lost");
    chk_no_ack_rx: assert property (!(ev_set[SIC_EV_ACK] && rx_mode)) // [RQ1]
        else $error("ack error in reception");
    chk_ack_error: assert property ((ev_set[SIC_EV_END] && !rx_mode // [RQ16]
        && line[1]) |=> evt_ff[SIC_EV_ACK])
        else $error("missing ack not flagged");
    chk_ack_drive: assert property ((state_ff == SIC_HIGH // [RQ3]
        && bit_ff == SIC_ACK_SLOT && rx_mode && $past(soe_ff)
        && soe_ff) |-> !sda_ff && sda_oe_ff)
        else $error("ack not driven");
    chk_nack_free: assert property ((state_ff == SIC_LOW // [RQ12]
        && bit_ff == SIC_ACK_SLOT && rx_mode && !soe_ff
        && $stable(soe_ff) && $past(sda_ff)) |-> !sda_oe_ff)
        else $error("ack driven on last byte");
    chk_irq_level: assert property (|(evt_ff & mask_ff) |-> irq_ff)
        else $error("interrupt not raised");
endmodule : sic_main

//--- hw/sic_sync.sv
/*
 * Two-flop synchroniser for the sensed pin levels.
 * Assumes inputs are asynchronous to core_clk.
 */
`timescale 1ns/1ps
module sic_sync
    import sic_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] d,
    output logic [1:0] q
);
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;

    // Lines idle high, so reset to the idle level.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_ff <= 2'h3;
            s2_ff <= 2'h3;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
        end
    end

    assign q = s2_ff;
endmodule : sic_sync

//--- hw/sic_tick.sv
/*
 * Prescaler giving one enable tick per channel operation clock period.
 * Assumes k is stable while the channel runs.
 */
`timescale 1ns/1ps
module sic_tick
    import sic_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] k,
    output logic tick
);
    logic [14:0] cnt_ff;
    logic [14:0] mask;

    function automatic logic [14:0] low_mask(input logic [3:0] n);
        logic [15:0] m;
        m = (16'h0001 << n) - 16'h0001;
        return m[14:0];
    endfunction : low_mask

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_ff <= 15'h0000;
        end else begin
            cnt_ff <= cnt_ff + 15'h0001;
        end
    end

    // A free counter avoids reloading when k changes.
    assign mask = low_mask(k);
    assign tick = (cnt_ff & mask) == mask; // [RQ9]

    chk_tick_rate: assert property (@(posedge core_clk) disable iff (reset)
        (tick && k != 4'h0) |=> !tick) else $error("tick too often"); // [RQ9]
endmodule : sic_tick

//--- pkg/sic_pkg.sv
/*
 * Shared constants and types of the simplified I2C master channel.
 * Assumes a 32-bit Avalon-MM register bus with word-indexed addresses.
 */
package sic_pkg;

    // Register word offsets.
    localparam logic [3:0] SIC_OFS_DATA = 4'h0;
    localparam logic [3:0] SIC_OFS_MODE = 4'h1;
    localparam logic [3:0] SIC_OFS_PRS = 4'h2;
    localparam logic [3:0] SIC_OFS_LVL = 4'h3;
    localparam logic [3:0] SIC_OFS_SOE = 4'h4;
    localparam logic [3:0] SIC_OFS_START = 4'h5;
    localparam logic [3:0] SIC_OFS_STOP = 4'h6;
    localparam logic [3:0] SIC_OFS_STAT = 4'h7;
    localparam logic [3:0] SIC_OFS_EVT = 4'h8;
    localparam logic [3:0] SIC_OFS_MASK = 4'h9;

    // Data register: divider field in bits 15:9, byte in bits 7:0.
    localparam int SIC_DIV_LSB = 9;
    localparam int SIC_DIV_MSB = 15;
    localparam logic [6:0] SIC_DIV_RST = 7'h01;

    // Mode register fields.
    localparam int SIC_CKS_BIT = 7;
    localparam int SIC_TXE_BIT = 1;
    localparam int SIC_RXE_BIT = 0;
    localparam logic [7:0] SIC_MODE_RST = 8'h02;
    localparam logic [7:0] SIC_PRS_RST = 8'h00;

    // Output level register: bit 0 data line, bit 1 clock line.
    localparam int SIC_LVL_SDA = 0;
    localparam int SIC_LVL_SCL = 1;
    localparam logic [1:0] SIC_LVL_RST = 2'h3;

    // Status register bits.
    localparam int SIC_ST_EN = 0;
    localparam int SIC_ST_TSF = 1;
    localparam int SIC_ST_BFF = 2;
    localparam int SIC_ST_SCL = 3;
    localparam int SIC_ST_SDA = 4;

    // Event status and mask bits.
    localparam int SIC_EV_END = 0;
    localparam int SIC_EV_OVF = 1;
    localparam int SIC_EV_ACK = 2;
    localparam logic [2:0] SIC_EV_RST = 3'h0;

    // Index of the acknowledge slot, the ninth bit of a frame.
    localparam logic [3:0] SIC_ACK_SLOT = 4'h8;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } sic_avm_req_t;

    typedef enum {SIC_IDLE, SIC_LOW, SIC_HIGH} sic_state_t;

endpackage : sic_pkg
